/* File: design/burst_read_config_sequencer.sv */
// Synchronous burst read sequencer with configuration word and handshake pin
`timescale 1ns/1ps
module burst_read_config_sequencer
  import burst_cfg_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16
) (
  // Clock and power-up reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Link pins from the host
  input  wire logic              k_pin,
  input  wire logic              latch_n_pin,
  input  wire logic [ADDR_W-1:0] addr_pin,
  input  wire logic              cfg_set_pin,
  input  wire logic [CFG_W-1:0]  cfg_data_pin,
  input  wire logic              hardware_reset_pulse_n,
  // Handshake pin, two-way
  input  wire logic              rw_in,
  output logic                   rw_out,
  output logic                   rw_oe,
  // Data pins
  output logic      [DATA_W-1:0] dq_out,
  output logic                   dq_oe,
  // Status
  output logic      [CFG_W-1:0]  read_configuration,
  output logic                   first_latch_restart_sequence,
  // Array preload, same clock
  input  wire logic              array_wr_en,
  input  wire logic [ADDR_W-1:0] array_wr_addr,
  input  wire logic [DATA_W-1:0] array_wr_data
);

  if (ADDR_W < 5 || DATA_W < 1) begin : g_bad_param
    $error("ADDR_W must be at least 5 to hold a 16-word boundary");
  end

  typedef struct packed {
    logic              k_meta;
    logic              k_sync;
    logic              k_prev;
    logic              l_meta;
    logic              l_sync;
    logic              r_meta;
    logic              r_sync;
    logic              rw_meta;
    logic              rw_sync;
    logic              s_meta;
    logic              s_sync;
    logic [ADDR_W-1:0] a_meta;
    logic [ADDR_W-1:0] a_sync;
    logic [CFG_W-1:0]  c_meta;
    logic [CFG_W-1:0]  c_sync;
    logic [CFG_W-1:0]  cfg;
    logic [INIT_W-1:0] init_cnt;
    logic              init_done;
    restart_phase_t    rphase;
    logic              restart;
    kind_t             kind;
    logic [2:0]        cnt;
    logic              hold_phase;
    logic [ADDR_W-1:0] addr;
    logic [1:0]        start_off;
    logic              crossed;
    logic [4:0]        words;
    logic              wait_q;
    logic [DATA_W-1:0] dq;
    logic              dq_en;
    logic              pin_out;
    logic              pin_oe;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic [DATA_W-1:0] rd_data;
  logic              rise;
  logic              fall;
  logic              act;
  logic [2:0]        lat_code;
  logic [2:0]        lat_eff;
  logic [2:0]        len_code;
  logic              cont;
  logic              wrap_on;
  logic [4:0]        len_words;
  logic [ADDR_W-1:0] blk_mask;
  logic [ADDR_W-1:0] inc_addr;
  logic [ADDR_W-1:0] nxt_addr;

  burst_word_store #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) u_store (
    .clk     (clk),
    .wr_en   (array_wr_en),
    .wr_addr (array_wr_addr),
    .wr_data (array_wr_data),
    .rd_addr (st_reg.addr),
    .rd_data (rd_data)
  );

  // Edge detection on the sampled link clock
  assign rise = st_reg.k_sync & ~st_reg.k_prev;
  assign fall = ~st_reg.k_sync & st_reg.k_prev;
  assign act  = st_reg.cfg[EDGE_POS] ? rise : fall;

  // Reserved latency codes behave as the default
  assign lat_code = st_reg.cfg[LAT_LSB +: 3];
  assign lat_eff  = (lat_code < LAT_MIN_CODE) ? LAT_DEFAULT : lat_code;

  // Unlisted length codes run as continuous
  assign len_code = st_reg.cfg[LEN_LSB +: 3];
  always_comb begin
    cont      = 1'b0;
    len_words = WORDS_16;
    blk_mask  = ADDR_W'(15);
    unique case (len_code)
      LEN_4: begin
        len_words = WORDS_4;
        blk_mask  = ADDR_W'(3);
      end
      LEN_8: begin
        len_words = WORDS_8;
        blk_mask  = ADDR_W'(7);
      end
      LEN_16: begin
        len_words = WORDS_16;
      end
      default: begin
        cont = 1'b1;
      end
    endcase
  end

  assign wrap_on  = ~cont & ~st_reg.cfg[WRAP_POS];
  // Order bit is not decoded; only sequential order exists
  assign inc_addr = st_reg.addr + ADDR_W'(1);
  assign nxt_addr = wrap_on ? ((st_reg.addr & ~blk_mask) | (inc_addr & blk_mask))
                            : inc_addr;

  always_comb begin
    st_next         = st_reg;
    st_next.restart = 1'b0;
    st_next.k_meta  = k_pin;
    st_next.k_sync  = st_reg.k_meta;
    st_next.k_prev  = st_reg.k_sync;
    st_next.l_meta  = latch_n_pin;
    st_next.l_sync  = st_reg.l_meta;
    st_next.r_meta  = hardware_reset_pulse_n;
    st_next.r_sync  = st_reg.r_meta;
    st_next.rw_meta = rw_in;
    st_next.rw_sync = st_reg.rw_meta;
    st_next.s_meta  = cfg_set_pin;
    st_next.s_sync  = st_reg.s_meta;
    st_next.a_meta  = addr_pin;
    st_next.a_sync  = st_reg.a_meta;
    st_next.c_meta  = cfg_data_pin;
    st_next.c_sync  = st_reg.c_meta;

    if (!st_reg.r_sync) begin
      // Hardware reset pulse restores defaults and restarts configuration
      st_next.cfg       = CFG_RESET;
      st_next.init_cnt  = '0;
      st_next.init_done = 1'b0;
      st_next.kind      = K_IDLE;
      st_next.rphase    = RS_WAIT_HIGH;
      st_next.wait_q    = 1'b0;
      st_next.dq_en     = 1'b0;
    end else if (!st_reg.init_done) begin
      if (st_reg.init_cnt == INIT_W'(INIT_CYCLES - 1)) begin
        st_next.init_done = 1'b1;
      end else begin
        st_next.init_cnt = st_reg.init_cnt + INIT_W'(1);
      end
    end else begin
      // Pulse must see high first, so our own released low is not a trigger
      if (st_reg.cfg[PINFN_POS]) begin
        unique case (st_reg.rphase)
          RS_WAIT_HIGH: if (st_reg.rw_sync) st_next.rphase = RS_WAIT_LOW;
          RS_WAIT_LOW:  if (!st_reg.rw_sync) st_next.rphase = RS_WAIT_RISE;
          RS_WAIT_RISE: if (st_reg.rw_sync) begin
            st_next.rphase  = RS_WAIT_LOW;
            st_next.restart = 1'b1;
          end
          default: st_next.rphase = RS_WAIT_HIGH;
        endcase
      end else begin
        st_next.rphase = RS_WAIT_HIGH;
      end

      if (st_next.restart) begin
        st_next.kind = K_IDLE;
      end else if (act && !st_reg.l_sync) begin
        if (st_reg.s_sync) begin
          // Reserved bits never stored
          st_next.cfg  = st_reg.c_sync & ~CFG_RSVD_MASK;
          st_next.kind = K_IDLE;
        end else if (st_reg.cfg[READ_MODE_POS]) begin
          st_next.kind = K_IDLE;
        end else begin
          // Internal sequence runs one active edge ahead of the pins
          st_next.kind       = K_LAT;
          st_next.cnt        = lat_eff - 3'h2;
          st_next.addr       = st_reg.a_sync;
          st_next.start_off  = st_reg.a_sync[1:0];
          st_next.crossed    = 1'b0;
          st_next.words      = 5'h00;
          st_next.hold_phase = 1'b0;
        end
      end else if (act) begin
        unique case (st_reg.kind)
          K_IDLE, K_END: begin
          end
          K_LAT: begin
            if (st_reg.cnt == 3'h0) begin
              st_next.kind       = K_DATA;
              st_next.words      = 5'h01;
              st_next.hold_phase = 1'b0;
            end else begin
              st_next.cnt = st_reg.cnt - 3'h1;
            end
          end
          K_DATA: begin
            if (st_reg.cfg[HOLD_POS] && !st_reg.hold_phase) begin
              st_next.hold_phase = 1'b1;
            end else if (!cont && st_reg.words == len_words) begin
              st_next.kind = K_END;
            end else begin
              st_next.addr = nxt_addr;
              if (nxt_addr[3:0] == 4'h0 && !wrap_on) begin
                st_next.crossed = 1'b1;
              end
              // Boundary wait only once, only from an unaligned start
              if (!wrap_on && !st_reg.crossed && nxt_addr[3:0] == 4'h0 &&
                  st_reg.start_off != 2'h0) begin
                st_next.kind = K_BWAIT;
                st_next.cnt  = {1'b0, st_reg.start_off - 2'h1};
              end else begin
                st_next.kind       = K_DATA;
                st_next.words      = st_reg.words + 5'h01;
                st_next.hold_phase = 1'b0;
              end
            end
          end
          K_BWAIT: begin
            if (st_reg.cnt == 3'h0) begin
              st_next.kind       = K_DATA;
              st_next.words      = st_reg.words + 5'h01;
              st_next.hold_phase = 1'b0;
            end else begin
              st_next.cnt = st_reg.cnt - 3'h1;
            end
          end
          default: st_next.kind = K_IDLE;
        endcase
      end

      // Pin stage shows the internal kind one active edge later
      if (act) begin
        if (st_reg.kind == K_DATA) begin
          st_next.dq = rd_data;
        end
        st_next.dq_en = (st_reg.kind != K_IDLE);
        if (st_reg.cfg[TIMING_POS]) begin
          st_next.wait_q = (st_next.kind != K_IDLE) && (st_next.kind != K_DATA);
        end else begin
          st_next.wait_q = (st_reg.kind != K_IDLE) && (st_reg.kind != K_DATA);
        end
      end
      if (st_next.restart || st_reg.cfg[READ_MODE_POS]) begin
        st_next.wait_q = 1'b0;
      end
    end

    // Handshake pin drive
    if (!st_next.init_done) begin
      st_next.pin_oe  = 1'b1;
      st_next.pin_out = 1'b0;
    end else if (st_next.cfg[PINFN_POS]) begin
      st_next.pin_oe  = 1'b0;
      st_next.pin_out = 1'b0;
    end else begin
      st_next.pin_oe  = 1'b1;
      st_next.pin_out = st_next.cfg[POL_POS] ? st_next.wait_q : ~st_next.wait_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg        <= '0;
      st_reg.cfg    <= CFG_RESET;
      st_reg.pin_oe <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rw_out                       = st_reg.pin_out;
  assign rw_oe                        = st_reg.pin_oe;
  assign dq_out                       = st_reg.dq;
  assign dq_oe                        = st_reg.dq_en;
  assign read_configuration           = st_reg.cfg;
  assign first_latch_restart_sequence = st_reg.restart;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_init_hold_low: assert property (
    !st_reg.init_done |-> (rw_oe && !rw_out))
    else $error("handshake pin not held low during configuration");

  a_ready_release: assert property (
    (st_reg.init_done && st_reg.cfg[PINFN_POS]) |-> !rw_oe)
    else $error("ready function drives the pin after configuration");

  a_wait_polarity: assert property (
    (st_reg.init_done && !st_reg.cfg[PINFN_POS]) |->
      (rw_oe && (rw_out == (st_reg.cfg[POL_POS] ? st_reg.wait_q : !st_reg.wait_q))))
    else $error("wait pin level does not follow polarity");

  a_latency_end: assert property (
    (st_reg.r_sync && st_reg.init_done && !st_next.restart && act && st_reg.l_sync &&
     st_reg.kind == K_LAT && st_reg.cnt == 3'h0) |=> (st_reg.kind == K_DATA))
    else $error("first data not issued when latency expires");

  a_hold_two: assert property (
    (st_reg.r_sync && !st_next.restart && act && st_reg.l_sync && st_reg.kind == K_DATA &&
     st_reg.cfg[HOLD_POS] && !st_reg.hold_phase) |=> ($stable(st_reg.addr) && st_reg.hold_phase))
    else $error("word not held for a second edge");

  a_bwait_count: assert property (
    (st_reg.kind != K_BWAIT ##1 st_reg.kind == K_BWAIT) |->
      (st_reg.cnt == {1'b0, st_reg.start_off - 2'h1} && st_reg.addr[3:0] == 4'h0))
    else $error("boundary wait length differs from start offset");

  a_bwait_once: assert property (
    (st_reg.crossed && st_reg.kind == K_DATA && !(act && !st_reg.l_sync)) |=>
      (st_reg.kind != K_BWAIT))
    else $error("boundary wait inserted twice in one burst");

  a_wrap_block: assert property (
    (wrap_on && st_reg.kind == K_DATA && !(act && !st_reg.l_sync) && st_reg.r_sync) |=>
      (st_reg.addr[ADDR_W-1:4] == $past(st_reg.addr[ADDR_W-1:4])))
    else $error("wrapped burst left its aligned block");

  a_end_count: assert property (
    (st_reg.kind != K_END ##1 st_reg.kind == K_END) |-> (st_reg.words == len_words && !cont))
    else $error("fixed burst ended at the wrong word count");

  a_restart_idle: assert property (
    first_latch_restart_sequence |-> (st_reg.kind == K_IDLE && st_reg.cfg[PINFN_POS]))
    else $error("restart pulse did not abort the burst");

  a_edge_select: assert property (
    (st_reg.r_sync && $changed(st_reg.dq)) |->
      ($past(st_reg.k_sync == st_reg.cfg[EDGE_POS]) &&
       ($past(st_reg.k_sync) != $past(st_reg.k_sync, 2))))
    else $error("data changed away from the selected clock edge");

endmodule

/* File: design/burst_word_store.sv */
// Small word array feeding the burst output, registered read
`timescale 1ns/1ps
module burst_word_store
  import burst_cfg_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16
) (
  // Clock
  input  wire logic              clk,
  // Write port
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  // Read port
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data
);

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // No reset on the array; contents are loaded before bursts
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

/* File: pkg/burst_cfg_pkg.sv */
// Constants and types for the burst read configuration sequencer
// Overview of operation
// - First data appears the programmed latency of active edges after address latch.
// - Wait function drives the handshake pin active low or high per polarity bit.
// - Ready function ignores polarity and uses the pin as a ready indicator.
// - Each word stays valid one active edge, or two when data hold is set.
// - Data is invalid while wait is asserted; host samples only when deasserted.
// - Stall timing 0 asserts wait during wait states; 1 asserts one cycle early.
// - Bursts are sequential only; host keeps the burst order bit at 1.
// - Edge select 0 uses the falling clock edge, 1 the rising edge.
// - Ready function holds the pin low during power-up and hardware reset configuration.
// - In ready function an external high-low-high pulse restarts first address latching.
// - Pin function 0 makes the pin a conventional wait output during bursts.
// - Wrap 0 keeps fixed bursts inside their aligned block; 1 crosses it.
// - One latch yields 4, 8, 16 words or an unbounded burst per length field.
// - Continuous bursts keep incrementing across bank boundaries without stopping.
// - No-wrap or continuous bursts insert start-offset wait cycles at first 16-word crossing.
// - Boundary wait cycles occur only once per burst.
// - Wrap mode runs word addresses modulo burst length within the aligned block.
// - No-wrap fixed bursts wait only when reaching a 16-word boundary from unaligned start.
// - Wrap bit has no effect in continuous mode.
// - Latency codes 2 to 7 select 2 to 7 clocks; others reserved; default 7.
// - Reset leaves the device in synchronous read mode.
package burst_cfg_pkg;

  localparam int          CFG_W         = 16;
  localparam logic [15:0] CFG_RESET     = 16'h3ddf;
  localparam logic [15:0] CFG_RSVD_MASK = 16'h4020;

  localparam int READ_MODE_POS = 15;
  localparam int LAT_LSB       = 11;
  localparam int POL_POS       = 10;
  localparam int HOLD_POS      = 9;
  localparam int TIMING_POS    = 8;
  localparam int EDGE_POS      = 6;
  localparam int PINFN_POS     = 4;
  localparam int WRAP_POS      = 3;
  localparam int LEN_LSB       = 0;

  localparam logic [2:0] LAT_MIN_CODE = 3'h2;
  localparam logic [2:0] LAT_DEFAULT  = 3'h7;
  localparam logic [2:0] LEN_4        = 3'h1;
  localparam logic [2:0] LEN_8        = 3'h2;
  localparam logic [2:0] LEN_16       = 3'h3;
  localparam logic [2:0] LEN_CONT     = 3'h7;

  localparam logic [4:0] WORDS_4  = 5'h04;
  localparam logic [4:0] WORDS_8  = 5'h08;
  localparam logic [4:0] WORDS_16 = 5'h10;

  // Internal configuration time after power-up or hardware reset
  localparam int INIT_TIME_NS  = 1000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int INIT_CYCLES   = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_W        = $clog2(INIT_CYCLES + 1);

  typedef enum logic [2:0] {
    K_IDLE  = 3'b000,
    K_LAT   = 3'b001,
    K_DATA  = 3'b010,
    K_BWAIT = 3'b011,
    K_END   = 3'b100
  } kind_t;

  typedef enum logic [1:0] {
    RS_WAIT_HIGH = 2'b00,
    RS_WAIT_LOW  = 2'b01,
    RS_WAIT_RISE = 2'b10
  } restart_phase_t;

endpackage

/* File: test/burst_read_config_sequencer_tb_top.sv */
// Self-checking bench for the burst read configuration sequencer
`timescale 1ns/1ps
module burst_read_config_sequencer_tb_top
  import burst_cfg_pkg::*;
;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  logic              clk                    = 1'b0;
  logic              rst_n                  = 1'b0;
  logic              hardware_reset_pulse_n = 1'b1;
  logic              array_wr_en            = 1'b0;
  logic [ADDR_W-1:0] array_wr_addr          = '0;
  logic [DATA_W-1:0] array_wr_data          = '0;
  logic              k_pin;
  logic              latch_n_pin;
  logic [ADDR_W-1:0] addr_pin;
  logic              cfg_set_pin;
  logic [CFG_W-1:0]  cfg_data_pin;
  logic              rw_wire;
  logic              rw_out;
  logic              rw_oe;
  logic [DATA_W-1:0] dq_out;
  logic              dq_oe;
  logic [CFG_W-1:0]  read_configuration;
  logic              first_latch_restart_sequence;
  int                n_mismatch = 0;
  int                compares   = 0;
  int                n_restart  = 0;
  int                sched      [$];
  int                n;
  logic              w;
  logic [15:0]       t_cfg      [8];
  int                t_start    [8];

  always #2 clk = ~clk;

  always @(posedge clk) if (first_latch_restart_sequence === 1'b1) n_restart++;

  burst_read_config_sequencer #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_dut (
    .clk, .rst_n, .k_pin, .latch_n_pin, .addr_pin, .cfg_set_pin, .cfg_data_pin,
    .hardware_reset_pulse_n, .rw_in(rw_wire), .rw_out, .rw_oe, .dq_out, .dq_oe,
    .read_configuration, .first_latch_restart_sequence, .array_wr_en, .array_wr_addr,
    .array_wr_data
  );

  host_link_model #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_host (
    .clk, .k_pin, .latch_n_pin, .addr_pin, .cfg_set_pin, .cfg_data_pin,
    .rw_out, .rw_oe, .rw_wire, .dq_out, .dq_oe
  );

  task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic test_done();
    if (n_mismatch == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wait_ready();
    for (int i = 0; i < 400 && rw_oe !== 1'b0; i++) @(negedge clk);
    check_bit("pin released", 1'b0, rw_oe);
  endtask

  // Wait function, sequential order; f is hold, timing, polarity, edge, wrap
  function automatic logic [15:0] mk(input logic [2:0] lat, input logic [4:0] f,
                                     input logic [2:0] len);
    return {2'b00, lat, f[2], f[4], f[3], 1'b1, f[1], 2'b00, f[0], len};
  endfunction

  // Expected schedule per active edge after the latch; -1 is a wait edge
  function automatic void plan(input logic [15:0] c, input int s);
    int   len;
    int   a;
    logic fix;
    logic crossed;
    sched.delete();
    len = (c[2:0] == LEN_4) ? 4 : (c[2:0] == LEN_8) ? 8 : (c[2:0] == LEN_16) ? 16 : 32;
    fix = (c[2:0] != LEN_CONT) && !c[WRAP_POS];
    crossed = 1'b0;
    for (int e = 1; e < c[LAT_LSB+:3]; e++) sched.push_back(-1);
    for (int k = 0; k < len; k++) begin
      a = fix ? s / len * len + (s + k) % len : s + k;
      if (k > 0 && a % 16 == 0 && !crossed && !fix) begin
        crossed = 1'b1;
        repeat (s % 4) sched.push_back(-1);
      end
      repeat (c[HOLD_POS] ? 2 : 1) sched.push_back(a);
    end
    repeat (3) sched.push_back(-1);
  endfunction

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (20) @(negedge clk);
    check_word("cfg after reset", 16'h3ddf, read_configuration);
    check_bit("wire in init", 1'b0, rw_wire);
    @(posedge clk);
    for (int i = 0; i < 256; i++) begin
      array_wr_en   <= 1'b1;
      array_wr_addr <= i[7:0];
      array_wr_data <= 16'hc000 | 16'(i);
      @(posedge clk);
    end
    array_wr_en <= 1'b0;
    wait_ready();
    // Latency 2 never meets two-cycle hold with early wait
    t_cfg   = '{mk(3'h3, 5'b00110, LEN_4) | 16'h4020, mk(3'h3, 5'b01110, LEN_4),
                mk(3'h2, 5'b10010, LEN_8), mk(3'h4, 5'b00101, LEN_4),
                mk(3'h5, 5'b01110, LEN_CONT), mk(3'h5, 5'b01111, LEN_CONT),
                mk(3'h7, 5'b10000, LEN_16), mk(3'h6, 5'b11111, LEN_16)};
    t_start = '{1, 1, 6, 13, 7, 7, 3, 2};
    foreach (t_cfg[i]) begin
      i_host.cfg_write(t_cfg[i]);
      @(negedge clk);
      check_word("config word", t_cfg[i] & 16'hbfdf, read_configuration);
      plan(t_cfg[i], t_start[i]);
      n = (t_cfg[i][2:0] == LEN_CONT) ? sched.size() - 4 : sched.size() - 1;
      i_host.burst(t_start[i][ADDR_W-1:0], n);
      for (int e = 1; e <= n; e++) begin
        w = t_cfg[i][TIMING_POS] ? (sched[e] < 0) : (sched[e-1] < 0);
        check_bit("wait level", w ~^ t_cfg[i][POL_POS], i_host.rw_cap[e]);
        check_bit("wait drive", 1'b1, i_host.oe_cap[e]);
        check_bit("data enable", 1'b1, i_host.dqoe_cap[e]);
        if (sched[e-1] >= 0) begin
          check_word("data word", 16'hc000 | 16'(sched[e-1] % 256), i_host.dq_cap[e]);
        end
      end
    end
    i_host.cfg_write(mk(3'h4, 5'b00111, LEN_4) | 16'h8000);
    i_host.burst(8'h00, 4);
    for (int e = 1; e <= 4; e++) begin
      check_bit("async data enable", 1'b0, i_host.dqoe_cap[e]);
      check_bit("async wait level", 1'b0, i_host.rw_cap[e]);
    end
    i_host.cfg_write(16'h39df);
    repeat (8) @(negedge clk);
    check_bit("ready drive", 1'b0, rw_oe);
    check_bit("ready wire", 1'b1, rw_wire);
    i_host.pulse();
    repeat (8) @(negedge clk);
    check_word("restart pulses", 16'h0001, 16'(n_restart));
    @(posedge clk);
    hardware_reset_pulse_n <= 1'b0;
    repeat (4) @(posedge clk);
    hardware_reset_pulse_n <= 1'b1;
    repeat (4) @(negedge clk);
    check_word("cfg after pulse", 16'h3ddf, read_configuration);
    check_bit("wire in reinit", 1'b0, rw_wire);
    wait_ready();
    test_done();
  end

  // Whole run needs well under 15000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
endmodule

/* File: test/host_link_model.sv */
// Host side model: read clock, address latch, config load and handshake wire
`timescale 1ns/1ps
module host_link_model
  import burst_cfg_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16
) (
  // System clock
  input  wire logic              clk,
  // Link pins
  output logic                   k_pin,
  output logic                   latch_n_pin,
  output logic      [ADDR_W-1:0] addr_pin,
  output logic                   cfg_set_pin,
  output logic      [CFG_W-1:0]  cfg_data_pin,
  // Handshake wire and data
  input  wire logic              rw_out,
  input  wire logic              rw_oe,
  output logic                   rw_wire,
  input  wire logic [DATA_W-1:0] dq_out,
  input  wire logic              dq_oe
);
  logic              idle_lvl = 1'b0;
  logic              pull_low = 1'b0;
  int                hp       = 4;
  logic [DATA_W-1:0] dq_cap   [64];
  logic              rw_cap   [64];
  logic              oe_cap   [64];
  logic              dqoe_cap [64];

  // Pull-up wins whenever nobody drives the wire and pull_low is off
  assign rw_wire = rw_oe ? rw_out : !pull_low;

  initial begin
    k_pin        = 1'b0;
    latch_n_pin  = 1'b1;
    addr_pin     = '0;
    cfg_set_pin  = 1'b0;
    cfg_data_pin = '0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Clock stands still between frames; capture late in the cycle
  task automatic edge_cycle(input int e);
    k_pin <= ~idle_lvl;
    tick(hp);
    k_pin <= idle_lvl;
    tick(2);
    @(negedge clk);
    dq_cap[e]   = dq_out;
    rw_cap[e]   = rw_out;
    oe_cap[e]   = rw_oe;
    dqoe_cap[e] = dq_oe;
    tick(hp - 2);
  endtask

  // Pins held around the latch edge, scrambled once their hold is over
  task automatic latch(input logic [ADDR_W-1:0] a, input logic cs, input logic [CFG_W-1:0] d);
    @(posedge clk);
    latch_n_pin  <= 1'b0;
    addr_pin     <= a;
    cfg_set_pin  <= cs;
    cfg_data_pin <= d;
    tick(2);
    k_pin <= ~idle_lvl;
    tick(hp);
    k_pin        <= idle_lvl;
    latch_n_pin  <= 1'b1;
    cfg_set_pin  <= 1'b0;
    addr_pin     <= ~a;
    cfg_data_pin <= ~d;
    tick(hp);
  endtask

  task automatic cfg_write(input logic [CFG_W-1:0] d);
    latch('0, 1'b1, d);
    if (idle_lvl !== ~d[EDGE_POS]) begin
      idle_lvl = ~d[EDGE_POS];
      k_pin <= idle_lvl;
      tick(hp);
    end
    // Slower read clock for short latencies; also slow enough for one-cycle hold
    hp = (d[LAT_LSB+:3] < 3'h4) ? 5 : 4;
  endtask

  task automatic burst(input logic [ADDR_W-1:0] a, input int n);
    latch(a, 1'b0, '0);
    for (int e = 1; e <= n; e++) edge_cycle(e);
  endtask

  // High, low, high on the released wire
  task automatic pulse();
    @(posedge clk);
    pull_low <= 1'b1;
    tick(4);
    pull_low <= 1'b0;
    tick(4);
  endtask
endmodule
